// ---- hdl/cpusr_pkg.sv ----
// package of constants and types for the cpu status and control registers
package cpusr_pkg;
    // memory size select codes
    localparam logic [7:0] CPUSR_MSS_RESET = 8'hFF;
    localparam logic [7:0] CPUSR_MSS_EE    = 8'hEE;
    localparam logic [7:0] CPUSR_MSS_DC    = 8'hDC;
    localparam logic [7:0] CPUSR_MSS_CC    = 8'hCC;
    // program counter, and status word reset value
    localparam int         CPUSR_PC_W      = 20;
    localparam logic [3:0] CPUSR_PC_HI_RST = 4'h0;
    localparam logic [15:0] CPUSR_PSW_RESET = 16'h0000;
    // lower half field positions
    localparam int CPUSR_CY  = 0;
    localparam int CPUSR_ZB  = 1;
    localparam int CPUSR_PV  = 2;
    localparam int CPUSR_IE  = 3;
    localparam int CPUSR_AC  = 4;
    localparam int CPUSR_RSS = 5;
    localparam int CPUSR_Z   = 6;
    localparam int CPUSR_S   = 7;
    // upper half field positions
    localparam int CPUSR_BANK_LO = 4;
    localparam int CPUSR_UF      = 7;
    // valid bit masks of each half
    localparam logic [7:0] CPUSR_LOW_MASK = 8'hFD;
    localparam logic [7:0] CPUSR_UP_MASK  = 8'hF0;

    // flag update classes of the executing instruction
    typedef enum logic [2:0] {
        CPUSR_OP_NONE  = 3'h0,
        CPUSR_OP_ARITH = 3'h1,
        CPUSR_OP_LOGIC = 3'h2,
        CPUSR_OP_SHIFT = 3'h3,
        CPUSR_OP_CHECK = 3'h4,
        CPUSR_OP_SHW   = 3'h5
    } cpusr_op_t;

    // program counter sequencer
    typedef enum logic [1:0] {
        CPUSR_ST_VEC_LO = 2'b00,
        CPUSR_ST_VEC_HI = 2'b01,
        CPUSR_ST_RUN    = 2'b11
    } cpusr_state_t;
endpackage

// ---- hdl/cpusr_flag_calc.sv ----
// flag computation from an alu result
`timescale 1ns/1ps
module cpusr_flag_calc (
    input  wire logic [15:0]         result_i,
    input  wire logic                wide_i,
    input  wire logic                carry_out_i,
    input  wire logic                carry_msb_in_i,
    input  wire logic                carry_b3_i,
    input  wire logic                shift_out_i,
    input  wire cpusr_pkg::cpusr_op_t op_i,
    output logic                     carry_o,
    output logic                     pv_o,
    output logic                     half_o,
    output logic                     zero_o,
    output logic                     sign_o
);
    import cpusr_pkg::*;
    logic even_lo;
    logic even_w;
    // even parity means a set flag
    assign even_lo = ~^result_i[7:0];
    assign even_w  = wide_i ? ~^result_i : even_lo;
    // flag values per class
    always_comb begin
        carry_o = (op_i == CPUSR_OP_ARITH) ? carry_out_i : shift_out_i;
        half_o  = carry_b3_i;
        zero_o  = wide_i ? (result_i == 16'h0000) : (result_i[7:0] == 8'h00);
        sign_o  = wide_i ? result_i[15] : result_i[7];
        case (op_i)
            CPUSR_OP_ARITH: pv_o = carry_msb_in_i ^ carry_out_i;
            CPUSR_OP_SHW:   pv_o = even_lo;
            default:        pv_o = even_w;
        endcase
    end
endmodule

// ---- hdl/cpusr_reg_map.sv ----
// implied register map chosen by the swap flag
`timescale 1ns/1ps
module cpusr_reg_map (
    input  wire logic       swap_i,
    output logic [3:0]      acc_o,
    output logic [3:0]      aux_o,
    output logic [3:0]      cnt_hi_o,
    output logic [3:0]      cnt_lo_o,
    output logic [2:0]      wide_accum_o,
    output logic [2:0]      wide_count_o
);
    // legacy code swaps the implied set to r4..r7
    always_comb begin
        acc_o        = swap_i ? 4'h5 : 4'h1;
        aux_o        = swap_i ? 4'h4 : 4'h0;
        cnt_hi_o     = swap_i ? 4'h7 : 4'h3;
        cnt_lo_o     = swap_i ? 4'h6 : 4'h2;
        wide_accum_o = swap_i ? 3'h2 : 3'h0;
        wide_count_o = swap_i ? 3'h3 : 3'h1;
    end
endmodule

// ---- hdl/cpusr_top.sv ----
// cpu status word, program counter and memory size select
`timescale 1ns/1ps
module cpusr_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 ce_i,
    // memory size select write
    input  wire logic                 mss_we_i,
    input  wire logic [7:0]           mss_wdata_i,
    // reset vector fetch
    input  wire logic                 vec_valid_i,
    input  wire logic [7:0]           vec_byte_i,
    // program counter control
    input  wire logic                 pc_adv_i,
    input  wire logic [2:0]           pc_len_i,
    input  wire logic                 pc_load_i,
    input  wire logic [19:0]          pc_target_i,
    // status byte access
    input  wire logic                 psw_lo_we_i,
    input  wire logic                 psw_hi_we_i,
    input  wire logic [7:0]           psw_wdata_i,
    // single bit access
    input  wire logic                 bit_we_i,
    input  wire logic [3:0]           bit_sel_i,
    input  wire logic                 bit_val_i,
    input  wire logic                 cy_we_i,
    input  wire logic                 cy_val_i,
    // alu result
    input  wire cpusr_pkg::cpusr_op_t alu_op_i,
    input  wire logic [15:0]          alu_result_i,
    input  wire logic                 alu_wide_i,
    input  wire logic                 alu_carry_i,
    input  wire logic                 alu_carry_msb_in_i,
    input  wire logic                 alu_carry_b3_i,
    input  wire logic                 alu_shift_out_i,
    // interrupt and context events
    input  wire logic                 ei_op_i,
    input  wire logic                 di_op_i,
    input  wire logic                 int_ack_i,
    input  wire logic                 break_op_i,
    input  wire logic                 stack_ret_i,
    input  wire logic [15:0]          stack_data_i,
    input  wire logic                 ctx_save_i,
    input  wire logic                 ctx_ret_i,
    input  wire logic [15:0]          pair_three_i,
    input  wire logic                 sel_bank_i,
    input  wire logic [2:0]           bank_i,
    // outputs
    output logic [7:0]                memory_size_select_o,
    output logic [19:0]               program_counter_o,
    output logic                      pc_ready_o,
    output logic [15:0]               processor_status_word_o,
    output logic                      push_o,
    output logic [15:0]               push_data_o,
    output logic                      pair_three_we_o,
    output logic [15:0]               pair_three_data_o,
    output logic                      maskable_ok_o,
    output logic [2:0]                bank_o,
    output logic [3:0]                implied_acc_o,
    output logic [2:0]                implied_wide_o
);
    import cpusr_pkg::*;

    typedef struct packed {
        cpusr_state_t st;
        logic         ready;
        logic [7:0]   mss;
        logic         mss_done;
        logic [19:0]  pc;
        logic [7:0]   lo;
        logic [7:0]   hi;
        logic         push;
        logic [15:0]  push_data;
        logic         p3_we;
        logic [15:0]  p3_data;
        logic [3:0]   acc;
        logic [2:0]   wide;
    } cpusr_state_s_t;

    cpusr_state_s_t r;
    cpusr_state_s_t next_r;

    logic       f_cy;
    logic       f_pv;
    logic       f_ac;
    logic       f_z;
    logic       f_s;
    logic [3:0] map_acc;
    logic [2:0] map_wa;
    logic [15:0] psw_now;

    cpusr_flag_calc u_flags (
        .result_i       (alu_result_i),
        .wide_i         (alu_wide_i),
        .carry_out_i    (alu_carry_i),
        .carry_msb_in_i (alu_carry_msb_in_i),
        .carry_b3_i     (alu_carry_b3_i),
        .shift_out_i    (alu_shift_out_i),
        .op_i           (alu_op_i),
        .carry_o        (f_cy),
        .pv_o           (f_pv),
        .half_o         (f_ac),
        .zero_o         (f_z),
        .sign_o         (f_s)
    );

    cpusr_reg_map u_map (
        .swap_i       (r.lo[CPUSR_RSS]),
        .acc_o        (map_acc),
        .aux_o        (),
        .cnt_hi_o     (),
        .cnt_lo_o     (),
        .wide_accum_o (map_wa),
        .wide_count_o ()
    );

    assign psw_now = {r.hi & CPUSR_UP_MASK, r.lo & CPUSR_LOW_MASK};

    // next state; later updates take priority over earlier ones
    always_comb begin
        next_r = r;
        next_r.push  = 1'b0;
        next_r.p3_we = 1'b0;
        // implied register map, registered so outputs come from flops
        next_r.acc  = map_acc;
        next_r.wide = map_wa;
        // size select takes only the first write; codes outside the list ignored
        if (mss_we_i && !r.mss_done) begin
            next_r.mss_done = 1'b1;
            if (mss_wdata_i == CPUSR_MSS_RESET || mss_wdata_i == CPUSR_MSS_EE ||
                mss_wdata_i == CPUSR_MSS_DC || mss_wdata_i == CPUSR_MSS_CC) begin
                next_r.mss = mss_wdata_i;
            end
        end
        // program counter sequencer
        case (r.st)
            CPUSR_ST_VEC_LO: begin
                if (vec_valid_i) begin
                    next_r.pc = {CPUSR_PC_HI_RST, 8'h00, vec_byte_i};
                    next_r.st = CPUSR_ST_VEC_HI;
                end
            end
            CPUSR_ST_VEC_HI: begin
                if (vec_valid_i) begin
                    next_r.pc = {CPUSR_PC_HI_RST, vec_byte_i, r.pc[7:0]};
                    next_r.st = CPUSR_ST_RUN;
                    next_r.ready = 1'b1;
                end
            end
            CPUSR_ST_RUN: begin
                if (pc_load_i) begin
                    next_r.pc = pc_target_i;
                end else if (pc_adv_i) begin
                    next_r.pc = r.pc + {17'h0_0000, pc_len_i};
                end
            end
            default: begin
                next_r.st    = CPUSR_ST_VEC_LO;
                next_r.ready = 1'b0;
            end
        endcase
        // alu flags; classes leave other flags as they were
        if (alu_op_i != CPUSR_OP_NONE) begin
            next_r.lo[CPUSR_S]  = f_s;
            next_r.lo[CPUSR_Z]  = f_z;
            next_r.lo[CPUSR_PV] = f_pv;
            if (alu_op_i == CPUSR_OP_ARITH) begin
                next_r.lo[CPUSR_AC] = f_ac;
                next_r.lo[CPUSR_CY] = f_cy;
            end else if (alu_op_i == CPUSR_OP_SHIFT || alu_op_i == CPUSR_OP_SHW) begin
                next_r.lo[CPUSR_CY] = f_cy;
            end
        end
        if (cy_we_i) begin
            next_r.lo[CPUSR_CY] = cy_val_i;
        end
        // single bit operations on either half
        if (bit_we_i) begin
            if (bit_sel_i[3]) begin
                next_r.hi[bit_sel_i[2:0]] = bit_val_i;
            end else begin
                next_r.lo[bit_sel_i[2:0]] = bit_val_i;
            end
        end
        if (psw_lo_we_i) begin
            next_r.lo = psw_wdata_i;
        end
        if (psw_hi_we_i) begin
            next_r.hi = psw_wdata_i;
        end
        if (sel_bank_i) begin
            next_r.hi[CPUSR_BANK_LO +: 3] = bank_i;
        end
        if (ei_op_i) begin
            next_r.lo[CPUSR_IE] = 1'b1;
        end
        if (di_op_i) begin
            next_r.lo[CPUSR_IE] = 1'b0;
        end
        // returns restore the whole word
        if (stack_ret_i) begin
            {next_r.hi, next_r.lo} = stack_data_i;
        end
        if (ctx_ret_i) begin
            {next_r.hi, next_r.lo} = pair_three_i;
        end
        // saves capture the word before this cycle's ack clears the enable
        if (int_ack_i || break_op_i) begin
            next_r.push      = 1'b1;
            next_r.push_data = psw_now;
        end
        if (ctx_save_i) begin
            next_r.p3_we   = 1'b1;
            next_r.p3_data = psw_now;
        end
        if (int_ack_i) begin
            next_r.lo[CPUSR_IE] = 1'b0;
        end
        next_r.lo[CPUSR_ZB] = 1'b0;
        next_r.hi[3:0]      = 4'h0;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r.st        <= CPUSR_ST_VEC_LO;
            r.ready     <= 1'b0;
            r.mss       <= CPUSR_MSS_RESET;
            r.mss_done  <= 1'b0;
            r.pc        <= 20'h0_0000;
            r.lo        <= CPUSR_PSW_RESET[7:0];
            r.hi        <= CPUSR_PSW_RESET[15:8];
            r.push      <= 1'b0;
            r.push_data <= 16'h0000;
            r.p3_we     <= 1'b0;
            r.p3_data   <= 16'h0000;
            r.acc       <= 4'h1;
            r.wide      <= 3'h0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign memory_size_select_o    = r.mss;
    assign program_counter_o       = r.pc;
    assign pc_ready_o              = r.ready;
    assign processor_status_word_o = {r.hi, r.lo};
    assign push_o                  = r.push;
    assign push_data_o             = r.push_data;
    assign pair_three_we_o         = r.p3_we;
    assign pair_three_data_o       = r.p3_data;
    assign maskable_ok_o           = r.lo[CPUSR_IE];
    assign bank_o                  = r.hi[CPUSR_BANK_LO +: 3];
    assign implied_acc_o           = r.acc;
    assign implied_wide_o          = r.wide;

    // size select stays at its value once written
    mss_once_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.mss_done && ce_i) |=> $stable(r.mss))
        else $error("size select changed after first write");

    // a first write with a code off the list leaves the reset value
    mss_code_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && mss_we_i && !r.mss_done && mss_wdata_i != CPUSR_MSS_EE && mss_wdata_i != CPUSR_MSS_DC
         && mss_wdata_i != CPUSR_MSS_CC) |=> memory_size_select_o == $past(memory_size_select_o))
        else $error("size select took a code off the list");

    pc_vec_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == CPUSR_ST_VEC_HI && vec_valid_i && ce_i) |=> program_counter_o[19:16] == 4'h0)
        else $error("pc upper bits not cleared at vector load");

    pc_ready_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == CPUSR_ST_VEC_HI && vec_valid_i && ce_i) |=> pc_ready_o)
        else $error("pc ready not raised after vector");

    pc_adv_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == CPUSR_ST_RUN && ce_i && pc_adv_i && !pc_load_i)
        |=> program_counter_o == $past(program_counter_o) + {17'h0_0000, $past(pc_len_i)})
        else $error("pc did not advance by length");

    // a branch load wins over the length advance
    pc_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == CPUSR_ST_RUN && ce_i && pc_load_i) |=> program_counter_o == $past(pc_target_i))
        else $error("pc did not take branch target");

    ie_ack_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (int_ack_i && ce_i) |=> !maskable_ok_o && push_o)
        else $error("ack did not clear enable and push");

    ei_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ei_op_i && !di_op_i && !int_ack_i && !stack_ret_i && !ctx_ret_i && !psw_lo_we_i && !bit_we_i && ce_i)
        |=> maskable_ok_o)
        else $error("enable op did not set flag");

    zero_bit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        processor_status_word_o[CPUSR_ZB] == 1'b0 && processor_status_word_o[11:8] == 4'h0)
        else $error("fixed zero bits set");

    ctx_save_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ctx_save_i && ce_i) |=> pair_three_we_o && pair_three_data_o == $past(psw_now))
        else $error("context save wrong");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && alu_op_i == CPUSR_OP_LOGIC && !cy_we_i && !bit_we_i && !psw_lo_we_i
         && !stack_ret_i && !ctx_ret_i) |=> $stable(processor_status_word_o[CPUSR_CY]))
        else $error("carry changed on logic op");

    // bit accumulator write, unless a later update of the lower half wins
    cy_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && cy_we_i && !bit_we_i && !psw_lo_we_i && !stack_ret_i && !ctx_ret_i)
        |=> processor_status_word_o[CPUSR_CY] == $past(cy_val_i))
        else $error("carry write lost");

    // the push strobe lasts one cycle only
    push_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (push_o && ce_i && !int_ack_i && !break_op_i) |=> !push_o)
        else $error("push strobe held too long");

    break_push_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (break_op_i && ce_i) |=> push_o && push_data_o == $past(psw_now))
        else $error("break did not push status");

    stack_ret_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (stack_ret_i && ce_i && !ctx_ret_i && !int_ack_i)
        |=> processor_status_word_o == ($past(stack_data_i) & {CPUSR_UP_MASK, CPUSR_LOW_MASK}))
        else $error("return did not restore status");

    bank_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (sel_bank_i && ce_i && !stack_ret_i && !ctx_ret_i) |=> bank_o == $past(bank_i))
        else $error("bank select not taken");
endmodule

// ---- sim/cpusr_tb_top.sv ----
// self-checking bench for the cpu status word, program counter and size select
`timescale 1ns/1ps
module cpu_status_and_control_regs_tb_top;
    import cpusr_pkg::*;
    logic        clk_i, rst_b_i, ce_i, mss_we_i, vec_valid_i, pc_adv_i, pc_load_i, psw_lo_we_i, psw_hi_we_i;
    logic        bit_we_i, bit_val_i, cy_we_i, cy_val_i, alu_wide_i, alu_carry_i, alu_carry_msb_in_i;
    logic        alu_carry_b3_i, alu_shift_out_i, ei_op_i, di_op_i, int_ack_i, break_op_i, stack_ret_i;
    logic        ctx_save_i, ctx_ret_i, sel_bank_i, pc_ready_o, push_o, pair_three_we_o, maskable_ok_o;
    logic [7:0]  mss_wdata_i, vec_byte_i, psw_wdata_i, memory_size_select_o;
    logic [2:0]  pc_len_i, bank_i, bank_o, implied_wide_o;
    logic [3:0]  bit_sel_i, implied_acc_o;
    logic [19:0] pc_target_i, program_counter_o;
    logic [15:0] alu_result_i, stack_data_i, pair_three_i, processor_status_word_o, push_data_o, pair_three_data_o;
    cpusr_op_t   alu_op_i, op;
    logic [15:0] m_psw, old;
    logic [19:0] m_pc;
    logic [11:0] st;
    logic [31:0] r, d;
    logic        prev_rss, wd;
    int          num_errors, compares, k;
    logic [7:0]  codes [5] = '{CPUSR_MSS_RESET, CPUSR_MSS_EE, CPUSR_MSS_DC, CPUSR_MSS_CC, 8'h5A};

    cpusr_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .mss_we_i(mss_we_i), .mss_wdata_i(mss_wdata_i),
        .vec_valid_i(vec_valid_i), .vec_byte_i(vec_byte_i), .pc_adv_i(pc_adv_i), .pc_len_i(pc_len_i),
        .pc_load_i(pc_load_i), .pc_target_i(pc_target_i), .psw_lo_we_i(psw_lo_we_i), .psw_hi_we_i(psw_hi_we_i),
        .psw_wdata_i(psw_wdata_i), .bit_we_i(bit_we_i), .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i),
        .cy_we_i(cy_we_i), .cy_val_i(cy_val_i), .alu_op_i(alu_op_i), .alu_result_i(alu_result_i),
        .alu_wide_i(alu_wide_i), .alu_carry_i(alu_carry_i), .alu_carry_msb_in_i(alu_carry_msb_in_i),
        .alu_carry_b3_i(alu_carry_b3_i), .alu_shift_out_i(alu_shift_out_i), .ei_op_i(ei_op_i),
        .di_op_i(di_op_i), .int_ack_i(int_ack_i), .break_op_i(break_op_i), .stack_ret_i(stack_ret_i),
        .stack_data_i(stack_data_i), .ctx_save_i(ctx_save_i), .ctx_ret_i(ctx_ret_i),
        .pair_three_i(pair_three_i), .sel_bank_i(sel_bank_i), .bank_i(bank_i),
        .memory_size_select_o(memory_size_select_o), .program_counter_o(program_counter_o),
        .pc_ready_o(pc_ready_o), .processor_status_word_o(processor_status_word_o), .push_o(push_o),
        .push_data_o(push_data_o), .pair_three_we_o(pair_three_we_o), .pair_three_data_o(pair_three_data_o),
        .maskable_ok_o(maskable_ok_o), .bank_o(bank_o), .implied_acc_o(implied_acc_o),
        .implied_wide_o(implied_wide_o));

    // 40 MHz core clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // inputs always move 2 ns after the rising edge, outputs are settled by then
    task automatic tick();
        @(posedge clk_i);
        #2;
    endtask

    // reset, then feed the two vector bytes low first
    task automatic boot();
        logic [15:0] v;
        int          n;
        v = 16'($urandom);
        rst_b_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #2;
        rst_b_i = 1'b1;
        chk(memory_size_select_o, 20'h0_00FF, "size select reset");
        chk(processor_status_word_o, 20'h0_0000, "status reset");
        chk(maskable_ok_o, 20'h0_0000, "interrupts off after reset");
        chk(pc_ready_o, 20'h0_0000, "pc not ready before vector");
        vec_valid_i = 1'b1;
        vec_byte_i = v[7:0];
        tick();
        vec_byte_i = v[15:8];
        tick();
        vec_valid_i = 1'b0;
        for (n = 0; n < 10 && pc_ready_o !== 1'b1; n++)
            tick();
        if (n == 10) begin
            num_errors++;
            tally_and_finish();
        end
        chk(program_counter_o, {4'h0, v}, "pc reset vector");
        chk(pc_ready_o, 20'h0_0001, "pc ready after vector");
        m_pc = {CPUSR_PC_HI_RST, v};
        m_psw = CPUSR_PSW_RESET;
        prev_rss = 1'b0;
    endtask

    initial begin
        {ce_i, rst_b_i} = 2'b10;
        {mss_we_i, vec_valid_i, pc_adv_i, pc_load_i, bit_val_i, cy_val_i, alu_wide_i} = '0;
        {alu_carry_i, alu_carry_msb_in_i, alu_carry_b3_i, alu_shift_out_i} = '0;
        {ctx_ret_i, ctx_save_i, stack_ret_i, break_op_i, int_ack_i, di_op_i, ei_op_i} = '0;
        {sel_bank_i, cy_we_i, bit_we_i, psw_hi_we_i, psw_lo_we_i} = '0;
        {mss_wdata_i, vec_byte_i, psw_wdata_i, pc_len_i, bank_i, bit_sel_i} = '0;
        {pc_target_i, alu_result_i, stack_data_i, pair_three_i} = '0;
        alu_op_i = CPUSR_OP_NONE;
        num_errors = 0;
        compares = 0;
        void'($urandom(72));
        // every size code after its own reset; a later write must not stick
        for (int i = 0; i < 5; i++) begin
            boot();
            mss_we_i = 1'b1;
            mss_wdata_i = codes[i];
            tick();
            chk(memory_size_select_o, (i == 4) ? 8'hFF : codes[i], "size select code");
            mss_wdata_i = codes[(i + 1) % 4];
            tick();
            mss_we_i = 1'b0;
            chk(memory_size_select_o, (i == 4) ? 8'hFF : codes[i], "size select rewrite");
        end
        // one random event a cycle, pc traffic beside it, model checked after every edge
        repeat (600) begin
            r = $urandom;
            d = $urandom;
            k = r[31:24] % 16;
            op = cpusr_op_t'(r[7:5] % 6);
            wd = (op == CPUSR_OP_SHW) | ((op == CPUSR_OP_ARITH) & r[8]);
            st = (k < 12) ? 12'h001 << k : 12'h000;
            {ctx_ret_i, ctx_save_i, stack_ret_i, break_op_i, int_ack_i, di_op_i, ei_op_i} = st[11:5];
            {sel_bank_i, cy_we_i, bit_we_i, psw_hi_we_i, psw_lo_we_i} = st[4:0];
            alu_op_i = (k >= 12) ? op : CPUSR_OP_NONE;
            ce_i = (r[23:20] != 4'h0);
            {psw_wdata_i, bank_i, bit_sel_i, bit_val_i, cy_val_i} = {d[7:0], d[2:0], d[3:0], d[4], d[0]};
            {stack_data_i, pair_three_i} = {d[15:0], d[15:0]};
            alu_result_i = wd ? d[15:0] : {8'h00, d[7:0]};
            {alu_wide_i, alu_carry_i, alu_carry_msb_in_i, alu_carry_b3_i, alu_shift_out_i} = {wd, r[12:9]};
            {pc_adv_i, pc_load_i, pc_len_i, pc_target_i} = {r[13], r[14], r[17:15], d[31:12]};
            old = m_psw;
            tick();
            if (ce_i) begin
                case (k)
                    0: m_psw[7:0] = d[7:0] & CPUSR_LOW_MASK;
                    1: m_psw[15:8] = d[7:0] & CPUSR_UP_MASK;
                    2: if (((d[3] ? CPUSR_UP_MASK : CPUSR_LOW_MASK) >> d[2:0]) & 8'h01) m_psw[d[3:0]] = d[4];
                    3: m_psw[CPUSR_CY] = d[0];
                    4: m_psw[14:12] = d[2:0];
                    5: m_psw[CPUSR_IE] = 1'b1;
                    6, 7: m_psw[CPUSR_IE] = 1'b0;
                    9, 11: m_psw = d[15:0] & {CPUSR_UP_MASK, CPUSR_LOW_MASK};
                    default: if (k >= 12 && op != CPUSR_OP_NONE) begin
                        m_psw[CPUSR_S] = wd ? d[15] : d[7];
                        m_psw[CPUSR_Z] = wd ? (d[15:0] == 16'h0000) : (d[7:0] == 8'h00);
                        // r[12] carry out, r[11] carry into msb, r[10] bit three carry, r[9] shift-out
                        m_psw[CPUSR_PV] = (op == CPUSR_OP_ARITH) ? r[11] ^ r[12] : ~^d[7:0];
                        if (op == CPUSR_OP_ARITH) {m_psw[CPUSR_CY], m_psw[CPUSR_AC]} = {r[12], r[10]};
                        if (op == CPUSR_OP_SHIFT || op == CPUSR_OP_SHW) m_psw[CPUSR_CY] = r[9];
                    end
                endcase
                // a branch load wins over the length advance
                m_pc = r[14] ? d[31:12] : (r[13] ? m_pc + 20'(r[17:15]) : m_pc);
                chk(push_o, (k == 7 || k == 8), "push pulse");
                if (k == 7 || k == 8) chk(push_data_o, old, "pushed word");
                chk(pair_three_we_o, (k == 10), "context save pulse");
                if (k == 10) chk(pair_three_data_o, old, "context saved word");
                chk(implied_acc_o, prev_rss ? 4'h5 : 4'h1, "implied accumulator");
                chk(implied_wide_o, prev_rss ? 3'h2 : 3'h0, "implied wide pair");
                prev_rss = m_psw[CPUSR_RSS];
            end
            chk(processor_status_word_o, m_psw, "status word");
            chk(maskable_ok_o, m_psw[CPUSR_IE], "maskable gate");
            chk(bank_o, m_psw[14:12], "bank select");
            chk(program_counter_o, m_pc, "program counter");
        end
        tally_and_finish();
    end
endmodule
